//--- include/utc_pkg.sv
package utc_pkg;
  // register byte addresses
  localparam logic [7:0] UTC_OFF_MODE = 8'h00;
  localparam logic [7:0] UTC_OFF_CMD = 8'h04;
  localparam logic [7:0] UTC_OFF_STAT = 8'h08;
  localparam logic [7:0] UTC_OFF_DATA = 8'h0c;
  localparam logic [7:0] UTC_OFF_BAUD = 8'h10;
  // channel_mode_reg_one fields
  localparam int UTC_M_LEN = 0;      // [1:0] data bits minus five
  localparam int UTC_M_PAR = 2;      // [3:2] 0 none, 1 even, 2 odd, 3 forced
  localparam int UTC_M_PFORCE = 4;
  localparam int UTC_M_STOP2 = 5;
  localparam int UTC_M_BLOCK = 6;
  localparam int UTC_M_RXRTS = 7;
  localparam int UTC_M_TXRTS = 8;
  localparam int UTC_M_CTSCHK = 9;
  localparam int UTC_M_REQFULL = 10;
  localparam int UTC_MODE_W = 11;
  localparam logic [UTC_MODE_W-1:0] UTC_MODE_RST = 11'h003;
  // channel_command_reg bits, each a one-shot action
  localparam int UTC_C_TXEN = 0;
  localparam int UTC_C_TXDIS = 1;
  localparam int UTC_C_RXEN = 2;
  localparam int UTC_C_RXDIS = 3;
  localparam int UTC_C_TXRST = 4;
  localparam int UTC_C_RXRST = 5;
  localparam int UTC_C_ERRRST = 6;
  localparam int UTC_C_BRKON = 7;
  localparam int UTC_C_BRKOFF = 8;
  localparam int UTC_C_RTSON = 9;
  localparam int UTC_C_RTSOFF = 10;
  // channel_status_reg bits
  localparam int UTC_S_RECEIVE_READY_FLAG = 0;
  localparam int UTC_S_FIFO_FULL_FLAG = 1;
  localparam int UTC_S_TRANSMIT_READY_FLAG = 2;
  localparam int UTC_S_TRANSMIT_EMPTY_FLAG = 3;
  localparam int UTC_S_OVR = 4;
  localparam int UTC_S_PE = 5;
  localparam int UTC_S_FE = 6;
  localparam int UTC_S_BRK = 7;
  localparam logic [15:0] UTC_BAUD_RST = 16'h000f;
  localparam logic [3:0] UTC_HALF_LAST = 4'h7;   // eight 16x ticks
  localparam logic [3:0] UTC_BIT_LAST = 4'hf;    // sixteen 16x ticks
  localparam logic [1:0] UTC_FIFO_DEPTH = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } utc_apb_req_s;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } utc_entry_s;

  typedef enum logic [2:0] {
    UTC_TX_IDLE = 3'b000, UTC_TX_START = 3'b001, UTC_TX_DATA = 3'b011,
    UTC_TX_PAR = 3'b010, UTC_TX_STOP = 3'b110
  } utc_tx_e;

  typedef enum logic [2:0] {
    UTC_RX_IDLE = 3'b000, UTC_RX_START = 3'b001, UTC_RX_DATA = 3'b011,
    UTC_RX_PAR = 3'b010, UTC_RX_STOP = 3'b110, UTC_RX_LOW = 3'b111,
    UTC_RX_BRK = 3'b101
  } utc_rx_e;
endpackage

//--- hdl/utc_channel.sv
// Notes on behaviour
// (RULE1) idle transmitter holds mark, shows empty; buffer write clears empty and restarts
// (RULE2) disable lets the character in the shifter finish before stopping
// (RULE3) transmitter reset stops at once; only enable command restarts
// (RULE4) with clear-to-send checking, start characters only while clear-to-send asserted
// (RULE5) send-break drives low and ignores clear-to-send
// (RULE6) transmitter rts mode: negate rts one bit after last character when disabled
// (RULE7) software asserts rts itself and sets transmit enable per message
// (RULE8) start bit checked over eight 16x ticks; any high sample abandons it
// (RULE9) bits sampled at centres, lsb first; unused upper bits read zero
// (RULE10) character queued and receive ready raised at stop bit middle
// (RULE11) nonzero char without stop, low half bit more, counts as new start
// (RULE12) error flags updated at character boundary, valid while receive ready
// (RULE13) low for whole character queues zero char with break; wait high half bit
// (RULE14) mid-character break queues damaged char, then zero break char
// (RULE15) shift register feeds three-entry fifo at topmost empty place
// (RULE16) each entry keeps data, parity, framing, break; overrun kept once
// (RULE17) receive ready while nonempty, fifo full at three; config picks request
// (RULE18) character mode shows top entry flags; block mode ORs arrivals at top
// (RULE19) status read leaves fifo; data read returns and pops top entry
// (RULE20) fifo full: char waits in shifter; next start loses it, sets overrun
// (RULE21) receiver rts mode: negate on valid start with fifo full, reassert on free
// (RULE22) disabled receiver still readable; receiver reset clears fifo, flags, request
// (RULE23) frame is start, data lsb first, optional parity, stop bits
// (RULE24) output rests at mark when disabled or idle
`timescale 1ns/100ps
module utc_channel
  import utc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire utc_pkg::utc_apb_req_s APB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RXD_I,
  input wire logic CTS_N_I,
  output logic TXD_O,
  output logic RTS_N_O,
  output logic RX_REQ_O
);
  import utc_pkg::*;

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] len, input logic [1:0] pm,
                                  input logic pf);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - len));
    par_of = (pm == 2'h3) ? pf : ((^m) ^ (pm == 2'h2));
  endfunction

  logic [UTC_MODE_W-1:0] mode_q;
  logic [15:0] baud_q, bcnt_q;
  logic tick_q;
  logic pready_q, pslverr_q, rd_top_q;
  logic [31:0] prdata_q;
  logic txd_q, rts_n_q, rx_req_q;
  logic tx_en_q, brk_q, rx_en_q;
  logic [7:0] thr_q, tx_sh_q;
  logic thr_full_q, tx_par_q;
  utc_tx_e tx_st_q;
  logic [3:0] tx_sub_q;
  logic [2:0] tx_bit_q;
  logic drop_q;
  logic [3:0] drop_cnt_q;
  utc_rx_e rx_st_q;
  logic [3:0] rx_sub_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_parbit_q, rxd_prev_q;
  utc_entry_s fifo_q [0:2];
  logic [1:0] cnt_q;
  logic pend_q, ovr_q;
  utc_entry_s pend_ent_q;
  logic [2:0] acc_q;

  logic [1:0] len;
  logic par_en;
  assign len = mode_q[UTC_M_LEN +: 2];
  assign par_en = mode_q[UTC_M_PAR +: 2] != 2'h0;

  // bus decode; a transfer completes on the second access-phase edge
  logic apb_go, wr_go, rd_go, mapped;
  logic [31:0] cmd;
  assign apb_go = APB_I.psel & APB_I.penable & pready_q;
  assign wr_go = apb_go & APB_I.pwrite;
  assign rd_go = apb_go & ~APB_I.pwrite;
  assign mapped = APB_I.paddr == UTC_OFF_MODE || APB_I.paddr == UTC_OFF_CMD || APB_I.paddr == UTC_OFF_STAT ||
                  APB_I.paddr == UTC_OFF_DATA || APB_I.paddr == UTC_OFF_BAUD;
  assign cmd = (wr_go && APB_I.paddr == UTC_OFF_CMD) ? APB_I.pwdata : 32'h0;

  // fifo bookkeeping
  logic pop, rx_done, start_ok, push_want, do_push, tx_load, tx_done;
  logic [1:0] cnt_after;
  utc_entry_s new_ent, push_ent;
  logic [2:0] arrive;
  logic [7:0] status;
  assign pop = rd_go && APB_I.paddr == UTC_OFF_DATA && rd_top_q && cnt_q != 2'h0;  // [RULE19]
  assign cnt_after = cnt_q - {1'b0, pop};
  assign push_want = rx_done | pend_q;
  assign do_push = push_want && cnt_after != UTC_FIFO_DEPTH;  // [RULE15] [RULE20]
  assign push_ent = rx_done ? new_ent : pend_ent_q;

  always_comb begin
    arrive = 3'h0;
    if (do_push && cnt_after == 2'h0) begin
      arrive = {push_ent.brk, push_ent.fe, push_ent.pe};
    end else if (pop && cnt_q >= 2'h2) begin
      arrive = {fifo_q[1].brk, fifo_q[1].fe, fifo_q[1].pe};
    end
  end

  always_comb begin
    status = 8'h0;
    status[UTC_S_RECEIVE_READY_FLAG] = cnt_q != 2'h0;  // [RULE17]
    status[UTC_S_FIFO_FULL_FLAG] = cnt_q == UTC_FIFO_DEPTH;
    status[UTC_S_TRANSMIT_READY_FLAG] = ~thr_full_q;
    status[UTC_S_TRANSMIT_EMPTY_FLAG] = ~thr_full_q && tx_st_q == UTC_TX_IDLE;  // [RULE1]
    status[UTC_S_OVR] = ovr_q;
    if (mode_q[UTC_M_BLOCK]) begin
      {status[UTC_S_BRK], status[UTC_S_FE], status[UTC_S_PE]} = acc_q;  // [RULE18]
    end else if (cnt_q != 2'h0) begin
      {status[UTC_S_BRK], status[UTC_S_FE], status[UTC_S_PE]} = {fifo_q[0].brk, fifo_q[0].fe, fifo_q[0].pe};
    end
  end

  // apb slave: one wait state, registered answer
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      rd_top_q <= 1'b0;
    end else begin
      pready_q <= APB_I.psel & APB_I.penable & ~pready_q;
      pslverr_q <= APB_I.psel & APB_I.penable & ~pready_q & ~mapped;
      rd_top_q <= cnt_q != 2'h0;
      prdata_q <= 32'h0;
      if (APB_I.psel && APB_I.penable && !pready_q && !APB_I.pwrite) begin
        unique case (APB_I.paddr)
          UTC_OFF_MODE: prdata_q <= {{(32-UTC_MODE_W){1'b0}}, mode_q};
          UTC_OFF_STAT: prdata_q <= {24'h0, status};  // [RULE12] [RULE19]
          UTC_OFF_DATA: prdata_q <= {24'h0, (cnt_q != 2'h0) ? fifo_q[0].data : 8'h0};
          UTC_OFF_BAUD: prdata_q <= {16'h0, baud_q};
          default: prdata_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_q <= UTC_MODE_RST;
      baud_q <= UTC_BAUD_RST;
    end else if (wr_go) begin
      if (APB_I.paddr == UTC_OFF_MODE) mode_q <= APB_I.pwdata[UTC_MODE_W-1:0];
      if (APB_I.paddr == UTC_OFF_BAUD) baud_q <= APB_I.pwdata[15:0];
    end
  end

  // 16x tick from the baud divider
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bcnt_q <= 16'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= bcnt_q == 16'h0;
      bcnt_q <= (bcnt_q == 16'h0) ? baud_q : bcnt_q - 16'h1;
    end
  end

  // transmitter control
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_en_q <= 1'b0;
      brk_q <= 1'b0;
    end else if (cmd[UTC_C_TXRST]) begin
      tx_en_q <= 1'b0;  // [RULE3]
      brk_q <= 1'b0;
    end else begin
      if (cmd[UTC_C_TXDIS]) tx_en_q <= 1'b0;
      else if (cmd[UTC_C_TXEN]) tx_en_q <= 1'b1;  // [RULE3] [RULE7]
      if (cmd[UTC_C_BRKOFF]) brk_q <= 1'b0;
      else if (cmd[UTC_C_BRKON]) brk_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      thr_q <= 8'h0;
      thr_full_q <= 1'b0;
    end else if (cmd[UTC_C_TXRST]) begin
      thr_full_q <= 1'b0;
    end else if (wr_go && APB_I.paddr == UTC_OFF_DATA && (!thr_full_q || tx_load)) begin
      thr_q <= APB_I.pwdata[7:0];
      thr_full_q <= 1'b1;  // [RULE1]
    end else if (tx_load) begin
      thr_full_q <= 1'b0;
    end
  end

  // clear-to-send only gates the start of a character
  assign tx_load = tick_q && tx_st_q == UTC_TX_IDLE && thr_full_q && tx_en_q && !brk_q && !cmd[UTC_C_TXRST] &&
                   (!mode_q[UTC_M_CTSCHK] || !CTS_N_I);  // [RULE4]
  assign tx_done = tick_q && tx_st_q == UTC_TX_STOP && tx_sub_q == UTC_BIT_LAST &&
                   !(mode_q[UTC_M_STOP2] && tx_bit_q == 3'h0);

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_st_q <= UTC_TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h0;
      tx_par_q <= 1'b0;
    end else if (cmd[UTC_C_TXRST]) begin
      tx_st_q <= UTC_TX_IDLE;  // [RULE3]
    end else if (tick_q) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      unique case (tx_st_q)
        UTC_TX_IDLE: begin
          tx_sub_q <= 4'h0;
          if (tx_load) begin
            tx_sh_q <= thr_q;
            tx_par_q <= par_of(thr_q, len, mode_q[UTC_M_PAR +: 2], mode_q[UTC_M_PFORCE]);
            tx_st_q <= UTC_TX_START;  // [RULE23]
          end
        end
        UTC_TX_START: if (tx_sub_q == UTC_BIT_LAST) begin
          tx_st_q <= UTC_TX_DATA;
          tx_bit_q <= 3'h0;
        end
        UTC_TX_DATA: if (tx_sub_q == UTC_BIT_LAST) begin
          tx_sh_q <= tx_sh_q >> 1;
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == {1'b1, len}) begin
            tx_st_q <= par_en ? UTC_TX_PAR : UTC_TX_STOP;
            tx_bit_q <= 3'h0;
          end
        end
        UTC_TX_PAR: if (tx_sub_q == UTC_BIT_LAST) tx_st_q <= UTC_TX_STOP;
        UTC_TX_STOP: if (tx_sub_q == UTC_BIT_LAST) begin
          tx_bit_q <= 3'h1;
          if (tx_done) tx_st_q <= UTC_TX_IDLE;  // [RULE2]
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      txd_q <= 1'b1;
    end else if (brk_q) begin
      txd_q <= 1'b0;  // [RULE5]
    end else begin
      unique case (tx_st_q)
        UTC_TX_START: txd_q <= 1'b0;  // [RULE23]
        UTC_TX_DATA: txd_q <= tx_sh_q[0];
        UTC_TX_PAR: txd_q <= tx_par_q;
        default: txd_q <= 1'b1;  // [RULE24]
      endcase
    end
  end

  // request-to-send: software, transmitter drop and receiver flow control
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      drop_q <= 1'b0;
      drop_cnt_q <= 4'h0;
    end else if (tx_done && !tx_en_q && mode_q[UTC_M_TXRTS]) begin
      drop_q <= 1'b1;  // [RULE6]
      drop_cnt_q <= 4'h0;
    end else if (drop_q && tick_q) begin
      drop_cnt_q <= drop_cnt_q + 4'h1;
      if (drop_cnt_q == UTC_BIT_LAST) drop_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rts_n_q <= 1'b1;
    end else if (cmd[UTC_C_RTSON]) begin
      rts_n_q <= 1'b0;
    end else if (cmd[UTC_C_RTSOFF]) begin
      rts_n_q <= 1'b1;
    end else if (drop_q && tick_q && drop_cnt_q == UTC_BIT_LAST) begin
      rts_n_q <= 1'b1;  // [RULE6]
    end else if (mode_q[UTC_M_RXRTS] && start_ok && cnt_q == UTC_FIFO_DEPTH) begin
      rts_n_q <= 1'b1;  // [RULE21]
    end else if (mode_q[UTC_M_RXRTS] && pop) begin
      rts_n_q <= 1'b0;  // [RULE21]
    end
  end

  // receiver
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_en_q <= 1'b0;
    end else if (cmd[UTC_C_RXRST] || cmd[UTC_C_RXDIS]) begin
      rx_en_q <= 1'b0;  // [RULE22]
    end else if (cmd[UTC_C_RXEN]) begin
      rx_en_q <= 1'b1;
    end
  end

  assign start_ok = tick_q && rx_st_q == UTC_RX_START && !RXD_I && rx_sub_q == UTC_HALF_LAST;
  assign rx_done = tick_q && rx_st_q == UTC_RX_STOP && rx_sub_q == UTC_BIT_LAST && !cmd[UTC_C_RXRST];
  assign new_ent.data = rx_sh_q;  // [RULE9]
  assign new_ent.fe = !RXD_I;
  assign new_ent.pe = par_en && (rx_parbit_q != par_of(rx_sh_q, len, mode_q[UTC_M_PAR +: 2], mode_q[UTC_M_PFORCE]));
  assign new_ent.brk = !RXD_I && rx_sh_q == 8'h0 && !(par_en && rx_parbit_q);  // [RULE13]

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_st_q <= UTC_RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h0;
      rx_parbit_q <= 1'b0;
      rxd_prev_q <= 1'b1;
    end else if (cmd[UTC_C_RXRST]) begin
      rx_st_q <= UTC_RX_IDLE;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_prev_q <= RXD_I;
      if (rx_st_q == UTC_RX_IDLE) begin
        rx_sub_q <= 4'h0;
        if (rx_en_q && rxd_prev_q && !RXD_I) rx_st_q <= UTC_RX_START;
      end else if (tick_q) begin
        rx_sub_q <= rx_sub_q + 4'h1;
        unique case (rx_st_q)
          UTC_RX_START: if (RXD_I) begin
            rx_st_q <= UTC_RX_IDLE;  // [RULE8]
          end else if (rx_sub_q == UTC_HALF_LAST) begin
            rx_st_q <= UTC_RX_DATA;  // [RULE8]
            rx_sub_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h0;
          end
          UTC_RX_DATA: if (rx_sub_q == UTC_BIT_LAST) begin
            rx_sh_q[rx_bit_q] <= RXD_I;  // [RULE9]
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == {1'b1, len}) rx_st_q <= par_en ? UTC_RX_PAR : UTC_RX_STOP;
          end
          UTC_RX_PAR: if (rx_sub_q == UTC_BIT_LAST) begin
            rx_parbit_q <= RXD_I;
            rx_st_q <= UTC_RX_STOP;
          end
          UTC_RX_STOP: if (rx_sub_q == UTC_BIT_LAST) begin
            rx_sub_q <= 4'h0;
            if (new_ent.brk) rx_st_q <= UTC_RX_BRK;  // [RULE13] [RULE14]
            else if (new_ent.fe) rx_st_q <= UTC_RX_LOW;  // [RULE11]
            else rx_st_q <= UTC_RX_IDLE;
          end
          UTC_RX_LOW: if (RXD_I) begin
            rx_st_q <= UTC_RX_IDLE;
          end else if (rx_sub_q == UTC_HALF_LAST) begin
            rx_st_q <= UTC_RX_START;  // [RULE11]
            rx_sub_q <= 4'h0;
          end
          UTC_RX_BRK: if (!RXD_I) begin
            rx_sub_q <= 4'h0;
          end else if (rx_sub_q == UTC_HALF_LAST) begin
            rx_st_q <= UTC_RX_IDLE;  // [RULE13]
          end
          default: rx_st_q <= UTC_RX_IDLE;
        endcase
      end
    end
  end

  // holding fifo, waiting character and flags
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 3; i++) fifo_q[i] <= '0;
      cnt_q <= 2'h0;
    end else if (cmd[UTC_C_RXRST]) begin
      cnt_q <= 2'h0;  // [RULE22]
    end else begin
      if (pop) begin
        for (int i = 0; i < 2; i++) fifo_q[i] <= fifo_q[i+1];  // [RULE19]
      end
      if (do_push) fifo_q[cnt_after] <= push_ent;  // [RULE10] [RULE15] [RULE16]
      cnt_q <= cnt_after + {1'b0, do_push};
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pend_q <= 1'b0;
      pend_ent_q <= '0;
    end else if (cmd[UTC_C_RXRST]) begin
      pend_q <= 1'b0;
    end else if (start_ok && pend_q && !do_push) begin
      pend_q <= 1'b0;  // [RULE20]
    end else if (rx_done && !do_push) begin
      pend_q <= 1'b1;  // [RULE20]
      pend_ent_q <= new_ent;
    end else if (do_push && !rx_done) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ovr_q <= 1'b0;
      acc_q <= 3'h0;
    end else if (cmd[UTC_C_RXRST]) begin
      ovr_q <= 1'b0;  // [RULE22]
      acc_q <= 3'h0;
    end else begin
      ovr_q <= (ovr_q && !cmd[UTC_C_ERRRST]) || (start_ok && pend_q && !do_push);  // [RULE20] [RULE12]
      acc_q <= (cmd[UTC_C_ERRRST] ? 3'h0 : acc_q) | arrive;  // [RULE18]
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_req_q <= 1'b0;
    end else begin
      rx_req_q <= mode_q[UTC_M_REQFULL] ? cnt_q == UTC_FIFO_DEPTH : cnt_q != 2'h0;  // [RULE17] [RULE22]
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign TXD_O = txd_q;
  assign RTS_N_O = rts_n_q;
  assign RX_REQ_O = rx_req_q;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_false_start;
    tick_q && rx_st_q == UTC_RX_START && RXD_I;
  endsequence
  sequence s_full_done;
    rx_done && cnt_q == UTC_FIFO_DEPTH && !pop;
  endsequence

  property p_mark_idle;
    tx_st_q == UTC_TX_IDLE && !brk_q |=> txd_q;
  endproperty
  a_mark_idle: assert property (p_mark_idle) else $error("line not at mark while idle");  // [RULE24]
  property p_break_low;
    brk_q |=> !txd_q;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not driving low");  // [RULE5]
  property p_cts_gate;
    tx_st_q == UTC_TX_IDLE && mode_q[UTC_M_CTSCHK] && CTS_N_I |=> tx_st_q == UTC_TX_IDLE;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("character started without clear-to-send");  // [RULE4]
  property p_txrst;
    cmd[UTC_C_TXRST] |=> tx_st_q == UTC_TX_IDLE && !tx_en_q ##1 txd_q;
  endproperty
  a_txrst: assert property (p_txrst) else $error("transmitter reset did not stop");  // [RULE3]
  property p_disable_drains;
    !tx_en_q && tx_st_q == UTC_TX_IDLE |=> tx_st_q == UTC_TX_IDLE;
  endproperty
  a_disable_drains: assert property (p_disable_drains) else $error("disabled transmitter restarted");  // [RULE2]
  property p_false_start;
    s_false_start |=> rx_st_q == UTC_RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start not abandoned");  // [RULE8]
  property p_fifo_full_flag;
    cnt_q <= UTC_FIFO_DEPTH && status[UTC_S_FIFO_FULL_FLAG] == (cnt_q == UTC_FIFO_DEPTH) && status[UTC_S_RECEIVE_READY_FLAG] == (cnt_q != 2'h0);
  endproperty
  a_fifo_full_flag: assert property (p_fifo_full_flag) else $error("fifo flags wrong");  // [RULE17]
  property p_wait_full;
    s_full_done ##0 !cmd[UTC_C_RXRST] |=> pend_q && cnt_q == UTC_FIFO_DEPTH;
  endproperty
  a_wait_full: assert property (p_wait_full) else $error("character not held in shifter");  // [RULE20]
  property p_pop;
    pop && !do_push && !cmd[UTC_C_RXRST] |=> cnt_q == $past(cnt_q) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("data read did not pop");  // [RULE19]
  property p_rxrst;
    cmd[UTC_C_RXRST] |=> cnt_q == 2'h0 && !ovr_q && !pend_q && !rx_en_q ##1 !rx_req_q;
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("receiver reset incomplete");  // [RULE22]
  property p_rts_drop;
    drop_q && tick_q && drop_cnt_q == UTC_BIT_LAST && !cmd[UTC_C_RTSON] |=> rts_n_q;
  endproperty
  a_rts_drop: assert property (p_rts_drop) else $error("rts not dropped after last character");  // [RULE6]
endmodule // utc_channel

//--- tb/utc_far_end.sv
`timescale 1ns/100ps
module utc_far_end (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic cts_n_o
);
  localparam int BIT = 16;
  logic [7:0] got[$];
  logic [7:0] sh;
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
  end
  task automatic set_cts(input logic v);
    cts_n_o <= v;
  endtask
  // start, eight data bits lsb first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
  task automatic brk(input int bits);
    rxd_o <= 1'b0;
    repeat (BIT * bits) @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
  // samples frames from the block at bit centres
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      sh[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    got.push_back(sh);
  end
endmodule // utc_far_end

//--- tb/test_uart_tx_rx_channel_fifo.sv
`timescale 1ns/100ps
module test_uart_tx_rx_channel_fifo;
  import utc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  utc_apb_req_s req = '0;
  logic [31:0] prdata, rdv, st;
  logic pready, pslverr, errv, txd, rts_n, rx_req, rxd, cts_n;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  utc_channel u_dut (.CLK_I(clk), .NRST_I(nrst), .APB_I(req), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .RXD_I(rxd), .CTS_N_I(cts_n), .TXD_O(txd), .RTS_N_O(rts_n), .RX_REQ_O(rx_req));
  utc_far_end u_far (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .cts_n_o(cts_n));
  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    req <= '0;
  endtask
  task automatic wait_got(input int n);
    while (u_far.got.size() < n) @(posedge clk);
  endtask
  task automatic t_reset;
    check(txd, 1'b1);
    apb(1'b0, UTC_OFF_MODE, 0);
    check(rdv, 32'(UTC_MODE_RST));
    apb(1'b0, 8'h14, 0);
    check(errv, 1'b1);
    apb(1'b1, UTC_OFF_BAUD, 0);
    apb(1'b1, UTC_OFF_CMD, b(UTC_C_TXEN) | b(UTC_C_RXEN));
  endtask
  task automatic t_tx;
    apb(1'b1, UTC_OFF_DATA, 32'ha5);
    apb(1'b1, UTC_OFF_DATA, 32'h3c);
    wait_got(2);
    check(u_far.got[0], 8'ha5);
    check(u_far.got[1], 8'h3c);
    repeat (40) @(posedge clk);
    apb(1'b0, UTC_OFF_STAT, 0);
    check(rdv[UTC_S_TRANSMIT_EMPTY_FLAG], 1'b1);
    check(txd, 1'b1);
    apb(1'b1, UTC_OFF_MODE, 32'h003 | b(UTC_M_TXRTS));
    apb(1'b1, UTC_OFF_CMD, b(UTC_C_RTSON) | b(UTC_C_TXEN));
    apb(1'b1, UTC_OFF_DATA, 32'h81);
    apb(1'b1, UTC_OFF_CMD, b(UTC_C_TXDIS));
    wait_got(3);
    check(u_far.got[2], 8'h81);
    check(rts_n, 1'b0);
    repeat (300) @(posedge clk);
    check(u_far.got.size(), 3);
    check(rts_n, 1'b1);
    check(txd, 1'b1);
  endtask
  task automatic t_cts;
    apb(1'b1, UTC_OFF_MODE, 32'h003 | b(UTC_M_CTSCHK));
    u_far.set_cts(1'b1);
    apb(1'b1, UTC_OFF_CMD, b(UTC_C_TXEN));
    apb(1'b1, UTC_OFF_DATA, 32'h5a);
    repeat (200) @(posedge clk);
    check(u_far.got.size(), 3);
    u_far.set_cts(1'b0);
    wait_got(4);
    check(u_far.got[3], 8'h5a);
    repeat (40) @(posedge clk);
    u_far.set_cts(1'b1);
    apb(1'b1, UTC_OFF_CMD, b(UTC_C_BRKON));
    repeat (5) @(posedge clk);
    check(txd, 1'b0);
    apb(1'b1, UTC_OFF_CMD, b(UTC_C_BRKOFF));
    apb(1'b1, UTC_OFF_MODE, 32'h003);
  endtask
  task automatic t_rx;
    logic [7:0] exp[4] = '{8'h11, 8'h22, 8'h33, 8'h55};
    foreach (exp[i]) u_far.send(i == 3 ? 8'h44 : exp[i]);
    u_far.send(8'h55);
    apb(1'b0, UTC_OFF_STAT, 0);
    st = rdv;
    check(st[UTC_S_RECEIVE_READY_FLAG], 1'b1);
    check(st[UTC_S_FIFO_FULL_FLAG], 1'b1);
    check(st[UTC_S_OVR], 1'b1);
    check(rx_req, 1'b1);
    apb(1'b0, UTC_OFF_STAT, 0);
    check(rdv, st);
    foreach (exp[i]) begin
      apb(1'b0, UTC_OFF_DATA, 0);
      check(rdv, 32'(exp[i]));
    end
    apb(1'b0, UTC_OFF_STAT, 0);
    check(rdv[UTC_S_RECEIVE_READY_FLAG], 1'b0);
    u_far.brk(12);
    repeat (20) @(posedge clk);
    apb(1'b0, UTC_OFF_STAT, 0);
    check(rdv[UTC_S_BRK], 1'b1);
    check(rdv[UTC_S_RECEIVE_READY_FLAG], 1'b1);
    apb(1'b0, UTC_OFF_DATA, 0);
    check(rdv, 32'h0);
    u_far.send(8'h3c);
    check(rx_req, 1'b1);
    apb(1'b1, UTC_OFF_DATA, 32'h77);
    apb(1'b1, UTC_OFF_CMD, b(UTC_C_TXRST) | b(UTC_C_RXRST));
    repeat (2) @(posedge clk);
    check(txd, 1'b1);
    apb(1'b0, UTC_OFF_STAT, 0);
    check(rdv[UTC_S_RECEIVE_READY_FLAG], 1'b0);
    check(rdv[UTC_S_TRANSMIT_EMPTY_FLAG], 1'b1);
    check(rx_req, 1'b0);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_cts();
    t_rx();
    final_report();
  end
endmodule // test_uart_tx_rx_channel_fifo
